// >>> core/pin_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser with a rising-edge pulse taken after the second flop
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out,
	output logic [WIDTH-1:0] rise_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] stable_reg;
	logic [WIDTH-1:0] last_reg;

	// First flop feeds only the second one
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_reg <= '0;
			stable_reg <= '0;
			last_reg <= '0;
		end else begin
			meta_reg <= pin_in;
			stable_reg <= meta_reg;
			last_reg <= stable_reg;
		end
	end

	assign level_out = stable_reg;
	assign rise_out = stable_reg & ~last_reg;
endmodule

// >>> core/readout_cmd_unit.sv
`timescale 1ns/1ps
`include "readout_consts.svh"
module readout_cmd_unit import readout_pkg::*; #(
	parameter int CHANNELS = 16
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] chip_addr_strap,
	input wire logic [39:0] bus_in,
	output logic [39:0] bus_out,
	output logic bus_oe_upper,
	output logic bus_oe_lower,
	input wire logic command_strobe_low,
	input wire logic write_low,
	output logic ack_low,
	output logic transfer_active,
	output logic data_strobe_low,
	input wire logic first_level_trigger,
	input wire logic sampling_clk,
	input wire logic acq_busy,
	input wire logic [15:0] channel_has_data,
	input wire logic [7:0] event_length,
	input wire logic [9:0] vpd_in,
	input wire logic [9:0] ped_mem_rdata,
	output logic [3:0] sel_channel,
	output logic [15:0] ped_mem_we,
	output logic [9:0] ped_mem_addr,
	output logic [9:0] ped_mem_wdata,
	output logic l1_accept,
	output logic rdo_start,
	output logic [3:0] rdo_channel,
	output logic rdo_ready,
	input wire logic rdo_valid,
	input wire logic [39:0] rdo_word,
	input wire logic rdo_done,
	output logic [16*8*13-1:0] coef_all,
	output logic [16*20-1:0] zs_all,
	output logic [16*10-1:0] fped_all,
	output logic [16*6-1:0] upper_bound_all,
	output logic [16*7-1:0] lower_bound_all,
	output logic [13:0] bc1_cfg,
	output logic [19:0] maf_cfg,
	output logic [19:0] trigger_timing_out,
	output logic [19:0] dpcfg_out,
	output logic [6:0] bfnpt_out,
	input wire logic signed [10:0] maf_sample,
	input wire logic [3:0] maf_chan,
	output logic maf_update_en,
	input wire logic [9:0] zs_sample,
	input wire logic [3:0] zs_chan,
	output logic zs_keep
);
	if (CHANNELS != 16) begin : g_chk
		$error("readout_cmd_unit serves exactly 16 channels");
	end

	state_t state_reg;
	logic command_strobe_low_s, write_s, l1_rise, sclk_rise;
	logic strobe_on, write_on, has_arg;
	logic [4:0] first_chan;
	logic [39:0] bus_s, word_reg;
	logic wr_reg, rdo_pending_reg, all_mode_reg, exec_pulse;
	logic [7:0] chip_reg;
	logic [9:0] pmp_reg;
	logic [13:0] bc1_reg;
	logic [19:0] maf_reg, trigger_timing_reg, dpcfg_reg;
	logic [6:0] bfnpt_reg;
	logic [12:0] coef_reg [16][8];
	logic [19:0] zs_reg [16];
	logic [9:0] fped_reg [16];
	logic [4:0] noise_reg [16];
	logic [2:0] wp_reg, rp_reg;
	logic [3:0] remain_reg;
	logic [15:0] trigger_count_reg;
	logic [7:0] err_reg;
	logic [19:0] rd_data;
	logic par_ok, broadcast_flag, addressed, illegal, full, empty, trig;
	logic [4:0] code;
	logic [3:0] chan, nbuf;
	logic [2:0] step;
	logic [4:0] nxt;

	// Cross strobe, write line and bus together so they stay aligned;
	// strobe and write enter inverted so cleared flops read as idle
	pin_sync #(.WIDTH(42)) bus_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pin_in({!command_strobe_low, !write_low, bus_in}),
		.level_out({strobe_on, write_on, bus_s}),
		.rise_out()
	);
	// Sampling clock is only watched for its rising edges
	pin_sync #(.WIDTH(2)) edge_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pin_in({first_level_trigger, sampling_clk}),
		.level_out(),
		.rise_out({l1_rise, sclk_rise})
	);

	function automatic access_t access_of(input logic [4:0] c);
		if (c <= `CODE_COEF_LAST)
			return ACC_RW;
		case (c)
			`CODE_ZS, `CODE_MAF, `CODE_TRIGGER_TIMING, `CODE_DPCFG, `CODE_BFNPT,
			`CODE_PMP, `CODE_BC1, `CODE_PEDPAIR, `CODE_PMWORD,
			`CODE_NOISE: return ACC_RW;
			`CODE_ERRSTAT, `CODE_TRIGGER_COUNT, `CODE_ADDRESS_AND_EVENT_LENGTH,
			`CODE_EMPTY: return ACC_RO;
			`CODE_WPADV, `CODE_RPADV, `CODE_CHRD, `CODE_SWTRIG,
			`CODE_TRCLEAR, `CODE_ERRCLEAR, `CODE_ALLRD: return ACC_CMD;
			default: return ACC_NONE;
		endcase
	endfunction

	// First non-empty channel at or above a start index, bit 4 = found
	function automatic logic [4:0] next_chan(input logic [15:0] map,
		input logic [4:0] from);
		logic [4:0] res;
		res = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (map[i] && i >= int'(from))
				res = {1'b1, 4'(i)};
		end
		return res;
	endfunction

	// Field split of the captured word
	assign command_strobe_low_s = !strobe_on;
	assign write_s = !write_on;
	// Reads and commands leave the low half floating; parity skips it
	assign has_arg = wr_reg && access_of(code) != ACC_CMD;
	assign par_ok = ~^{word_reg[39:20],
		has_arg ? word_reg[19:0] : 20'h00000};
	assign broadcast_flag = word_reg[`BIT_BROADCAST_FLAG];
	assign code = word_reg[`CODE_HI:`CODE_LO];
	assign chan = word_reg[`CHAN_HI:`CHAN_LO];
	assign addressed = broadcast_flag || word_reg[`CHIP_HI:`CHIP_LO] == chip_reg;
	assign illegal = access_of(code) == ACC_NONE
		|| (access_of(code) == ACC_RO && wr_reg)
		|| (access_of(code) == ACC_CMD && !wr_reg)
		|| (broadcast_flag && !wr_reg)
		|| (broadcast_flag && (code == `CODE_BC1 || code == `CODE_CHRD
		|| code == `CODE_ALLRD))
		|| word_reg[`BIT_ZERO];
	assign exec_pulse = state_reg == ST_EXEC && sclk_rise;
	assign nbuf = bfnpt_reg[`NBUF_BIT] ? `NBUF_LARGE : `NBUF_SMALL;
	assign step = bfnpt_reg[`NBUF_BIT] ? 3'h1 : 3'h2;
	assign full = remain_reg == 4'h0;
	assign empty = remain_reg == nbuf;
	assign sel_channel = chan;
	assign nxt = next_chan(channel_has_data, 5'(rdo_channel) + 5'h01);
	assign first_chan = next_chan(channel_has_data, 5'h00);
	// Software trigger behaves exactly like the pin
	assign trig = l1_rise
		|| (exec_pulse && code == `CODE_SWTRIG);
	// Suspended while a new acquisition runs
	assign rdo_ready = state_reg == ST_READOUT && !acq_busy;

	// Chip address strap is caught while reset is held
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			chip_reg <= chip_addr_strap;
	end

	// Instruction handshake and readout sequencing
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			word_reg <= 40'h0000000000;
			wr_reg <= 1'b0;
			rdo_pending_reg <= 1'b0;
			all_mode_reg <= 1'b0;
			rdo_channel <= 4'h0;
			rdo_start <= 1'b0;
		end else begin
			rdo_start <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (!command_strobe_low_s) begin
						word_reg <= bus_s;
						wr_reg <= !write_s;
						state_reg <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					rdo_pending_reg <= 1'b0;
					if (!addressed)
						state_reg <= ST_RELEASE;
					else if (!par_ok || illegal)
						state_reg <= broadcast_flag ? ST_RELEASE : ST_ACK;
					else if (code == `CODE_CHRD) begin
						rdo_pending_reg <= channel_has_data[chan] && !empty;
						all_mode_reg <= 1'b0;
						rdo_channel <= chan;
						state_reg <= ST_ACK;
					end else if (code == `CODE_ALLRD) begin
						rdo_pending_reg <= first_chan[4] && !empty;
						all_mode_reg <= 1'b1;
						rdo_channel <= first_chan[3:0];
						state_reg <= ST_ACK;
					end else
						state_reg <= ST_EXEC;
				end
				ST_EXEC: begin
					// Work lands on a sampling clock edge; blocked without it
					if (sclk_rise)
						state_reg <= broadcast_flag ? ST_RELEASE : ST_ACK;
				end
				ST_ACK: begin
					if (command_strobe_low_s) begin
						state_reg <= rdo_pending_reg ? ST_READOUT : ST_IDLE;
						rdo_start <= rdo_pending_reg;
					end
				end
				ST_RELEASE: begin
					if (command_strobe_low_s)
						state_reg <= ST_IDLE;
				end
				ST_READOUT: begin
					// Whole-chip mode steps over empty channels
					if (rdo_done) begin
						if (all_mode_reg && nxt[4]) begin
							rdo_channel <= nxt[3:0];
							rdo_start <= 1'b1;
						end else
							state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Pin drivers: answer on the low half, whole bus while reading out
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ack_low <= 1'b1;
			bus_out <= 40'h0000000000;
			bus_oe_upper <= 1'b0;
			bus_oe_lower <= 1'b0;
			transfer_active <= 1'b0;
			data_strobe_low <= 1'b1;
		end else begin
			ack_low <= !(state_reg == ST_ACK && !command_strobe_low_s);
			transfer_active <= state_reg == ST_READOUT;
			bus_oe_upper <= state_reg == ST_READOUT;
			bus_oe_lower <= state_reg == ST_READOUT
				|| (state_reg == ST_ACK && !wr_reg && !command_strobe_low_s);
			data_strobe_low <= !(rdo_ready && rdo_valid);
			if (state_reg == ST_EXEC && !wr_reg)
				bus_out <= {20'h00000, rd_data};
			else if (rdo_ready && rdo_valid)
				bus_out <= rdo_word;
		end
	end

	// Read-back multiplexer; narrow values are zero-filled
	always_comb begin
		rd_data = 20'h00000;
		if (code <= `CODE_COEF_LAST)
			rd_data = {7'h00, coef_reg[chan][code[2:0]]};
		else
			case (code)
				`CODE_ZS: rd_data = zs_reg[chan];
				`CODE_MAF: rd_data = maf_reg;
				`CODE_TRIGGER_TIMING: rd_data = trigger_timing_reg;
				`CODE_DPCFG: rd_data = dpcfg_reg;
				`CODE_BFNPT: rd_data = {13'h0000, bfnpt_reg};
				`CODE_PMP: rd_data = {10'h000, pmp_reg};
				`CODE_BC1: rd_data = {6'h00, bc1_reg};
				`CODE_PEDPAIR: rd_data = {vpd_in, fped_reg[chan]};
				`CODE_ERRSTAT: rd_data = {err_reg, empty, full, remain_reg,
					wp_reg, rp_reg};
				`CODE_PMWORD: rd_data = {10'h000, ped_mem_rdata};
				`CODE_TRIGGER_COUNT: rd_data = {4'h0, trigger_count_reg};
				`CODE_ADDRESS_AND_EVENT_LENGTH: rd_data = {4'h0, chip_reg, event_length};
				`CODE_NOISE: rd_data = {15'h0000, noise_reg[chan]};
				`CODE_EMPTY: rd_data = {4'h0, channel_has_data};
				default: rd_data = 20'h00000;
			endcase
	end

	// Global configuration registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pmp_reg <= 10'(`RST_CFG);
			bc1_reg <= 14'(`RST_CFG);
			maf_reg <= `RST_CFG;
			trigger_timing_reg <= `RST_CFG;
			dpcfg_reg <= `RST_CFG;
			bfnpt_reg <= 7'(`RST_CFG);
		end else if (exec_pulse && wr_reg) begin
			case (code)
				`CODE_PMP: pmp_reg <= word_reg[9:0];
				`CODE_BC1: bc1_reg <= word_reg[13:0];
				`CODE_MAF: maf_reg <= word_reg[`ARG_HI:0];
				`CODE_TRIGGER_TIMING: trigger_timing_reg <= word_reg[`ARG_HI:0];
				`CODE_DPCFG: dpcfg_reg <= word_reg[`ARG_HI:0];
				`CODE_BFNPT: bfnpt_reg <= word_reg[6:0];
				default: pmp_reg <= pmp_reg;
			endcase
		end
	end

	// Per-channel registers; broadcast writes every channel
	for (genvar i = 0; i < 16; i++) begin : g_ch
		logic hit;
		assign hit = exec_pulse && wr_reg && (broadcast_flag || chan == 4'(i));
		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				for (int k = 0; k < 8; k++)
					coef_reg[i][k] <= 13'(`RST_CFG);
				zs_reg[i] <= `RST_CFG;
				fped_reg[i] <= 10'(`RST_CFG);
				noise_reg[i] <= 5'(`RST_CFG);
			end else if (hit) begin
				if (code <= `CODE_COEF_LAST)
					coef_reg[i][code[2:0]] <= word_reg[12:0];
				if (code == `CODE_ZS)
					zs_reg[i] <= word_reg[`ARG_HI:0];
				if (code == `CODE_PEDPAIR)
					fped_reg[i] <= word_reg[9:0];
				if (code == `CODE_NOISE)
					noise_reg[i] <= word_reg[4:0];
			end
		end
		// Acceptance window per channel
		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				upper_bound_all[i*6 +: 6] <= 6'h00;
				lower_bound_all[i*7 +: 7] <= 7'h00;
			end else begin
				upper_bound_all[i*6 +: 6] <= {1'b0,
					bc1_reg[9:`BC1_HI_LO]} + {1'b0, noise_reg[i]};
				lower_bound_all[i*7 +: 7] <= 7'h00 - ({2'b00,
					bc1_reg[4:0]} + {2'b00, noise_reg[i]});
			end
		end
		for (genvar k = 0; k < 8; k++) begin : g_k
			assign coef_all[(i*8+k)*13 +: 13] = coef_reg[i][k];
		end
		assign zs_all[i*20 +: 20] = zs_reg[i];
		assign fped_all[i*10 +: 10] = fped_reg[i];
	end

	assign bc1_cfg = bc1_reg;
	assign maf_cfg = maf_reg;
	assign trigger_timing_out = trigger_timing_reg;
	assign dpcfg_out = dpcfg_reg;
	assign bfnpt_out = bfnpt_reg;

	// Pedestal memory write strobes share one pointer for all channels
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ped_mem_we <= 16'h0000;
			ped_mem_addr <= 10'h000;
			ped_mem_wdata <= 10'h000;
		end else begin
			ped_mem_addr <= pmp_reg;
			ped_mem_wdata <= word_reg[9:0];
			for (int i = 0; i < 16; i++)
				ped_mem_we[i] <= exec_pulse && wr_reg
					&& code == `CODE_PMWORD && (broadcast_flag || chan == 4'(i));
		end
	end

	// Multi-event buffer pointers; a write to the BFNPT register restarts them
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wp_reg <= 3'h0;
			rp_reg <= 3'h0;
			remain_reg <= `RST_REMAIN;
		end else if (exec_pulse && wr_reg && code == `CODE_BFNPT) begin
			wp_reg <= 3'h0;
			rp_reg <= 3'h0;
			remain_reg <= word_reg[`NBUF_BIT] ? `NBUF_LARGE : `NBUF_SMALL;
		end else if (exec_pulse && code == `CODE_WPADV && !full) begin
			wp_reg <= wp_reg + step;
			remain_reg <= remain_reg - 4'h1;
		end else if (exec_pulse && code == `CODE_RPADV && !empty) begin
			rp_reg <= rp_reg + step;
			remain_reg <= remain_reg + 4'h1;
		end
	end

	// Trigger counter counts ignored triggers too; a new one beats clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			trigger_count_reg <= 16'h0000;
			l1_accept <= 1'b0;
		end else begin
			l1_accept <= trig && !full;
			if (exec_pulse && code == `CODE_TRCLEAR)
				trigger_count_reg <= trig ? 16'h0001 : 16'h0000;
			else if (trig)
				trigger_count_reg <= trigger_count_reg + 16'h0001;
		end
	end

	// Sticky error flags; setting events win over the clear command
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			err_reg <= 8'h00;
		else begin
			if (exec_pulse && code == `CODE_ERRCLEAR)
				err_reg <= 8'h00;
			if (state_reg == ST_CHECK && addressed && !par_ok)
				err_reg[0] <= 1'b1;
			if (state_reg == ST_CHECK && addressed && par_ok && illegal)
				err_reg[1] <= 1'b1;
			if (trig && acq_busy)
				err_reg[2] <= 1'b1;
			if (state_reg == ST_CHECK && addressed && par_ok && !illegal
				&& (code == `CODE_CHRD || code == `CODE_ALLRD)
				&& !(code == `CODE_CHRD ? channel_has_data[chan] && !empty
				: channel_has_data != 16'h0000 && !empty))
				err_reg[7] <= 1'b1;
		end
	end

	// Datapath decisions, registered
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			maf_update_en <= 1'b0;
			zs_keep <= 1'b0;
		end else begin
			maf_update_en <= maf_sample <= $signed({2'b00,
				maf_reg[17:`MAF_HI_LO]}) + $signed({6'h00, noise_reg[maf_chan]})
				&& maf_sample >= -($signed({2'b00, maf_reg[8:0]})
				+ $signed({6'h00, noise_reg[maf_chan]}));
			zs_keep <= zs_sample >= zs_reg[zs_chan][9:0];
		end
	end
endmodule

// >>> core/readout_consts.svh
`ifndef READOUT_CONSTS_SVH
`define READOUT_CONSTS_SVH

// Instruction word field positions
`define BIT_PARITY 39
`define BIT_BROADCAST_FLAG 38
`define BIT_ZERO 37
`define CHIP_HI 36
`define CHIP_LO 29
`define CHAN_HI 28
`define CHAN_LO 25
`define CODE_HI 24
`define CODE_LO 20
`define ARG_HI 19

// Instruction codes
`define CODE_COEF_LAST 5'h07
`define CODE_ZS 5'h08
`define CODE_MAF 5'h09
`define CODE_TRIGGER_TIMING 5'h0a
`define CODE_DPCFG 5'h0b
`define CODE_BFNPT 5'h0c
`define CODE_PMP 5'h0d
`define CODE_BC1 5'h0e
`define CODE_PEDPAIR 5'h0f
`define CODE_ERRSTAT 5'h10
`define CODE_PMWORD 5'h11
`define CODE_TRIGGER_COUNT 5'h12
`define CODE_ADDRESS_AND_EVENT_LENGTH 5'h13
`define CODE_NOISE 5'h14
`define CODE_EMPTY 5'h17
`define CODE_WPADV 5'h18
`define CODE_RPADV 5'h19
`define CODE_CHRD 5'h1a
`define CODE_SWTRIG 5'h1b
`define CODE_TRCLEAR 5'h1c
`define CODE_ERRCLEAR 5'h1d
`define CODE_ALLRD 5'h1e

// Field positions inside registers
`define BC1_N_LO 10
`define BC1_HI_LO 5
`define MAF_TAPS_LO 18
`define MAF_HI_LO 9
`define NBUF_BIT 4

// Reset values and buffer counts
`define RST_CFG 20'h00000
`define RST_REMAIN 4'h4
`define NBUF_SMALL 4'h4
`define NBUF_LARGE 4'h8

`endif

// >>> core/readout_pkg.sv
package readout_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CHECK = 3'b001,
		ST_EXEC = 3'b010,
		ST_ACK = 3'b011,
		ST_RELEASE = 3'b100,
		ST_READOUT = 3'b101
	} state_t;
	typedef enum logic [1:0] {
		ACC_NONE = 2'b00,
		ACC_RW = 2'b01,
		ACC_RO = 2'b10,
		ACC_CMD = 2'b11
	} access_t;
endpackage

// >>> verification/readout_ctrl_model.sv
`timescale 1ns/1ps
// Readout controller: bus master, one instruction at a time
module readout_ctrl_model (
	input wire logic ref_clk,
	input wire logic ack_low,
	input wire logic [39:0] bus_out,
	output logic [39:0] bus_in,
	output logic command_strobe_low,
	output logic write_low
);
	initial begin
		bus_in = 40'h0;
		command_strobe_low = 1'b1;
		write_low = 1'b1;
	end
	// Hold the word until acknowledge; broadcasts get no answer, so they
	// are held for a fixed span long enough for a sampling clock edge
	task automatic issue(input logic [39:0] w, input logic wr,
		input logic arg, output logic [19:0] rd, output logic acked);
		int n;
		n = 0;
		acked = 1'b0;
		rd = 20'h0;
		@(posedge ref_clk);
		#1;
		bus_in[39:20] = w[39:20];
		if (arg) bus_in[19:0] = w[19:0];
		else bus_in[19:0] = ~bus_in[19:0]; // Undriven half drifts
		command_strobe_low = 1'b0;
		write_low = !wr;
		while (!acked && n < 60) begin
			@(negedge ref_clk);
			n++;
			if (!ack_low) begin
				acked = 1'b1;
				rd = bus_out[19:0];
			end
		end
		@(posedge ref_clk);
		#1;
		command_strobe_low = 1'b1;
		write_low = 1'b1;
		bus_in = ~bus_in;
		n = 0;
		while (!ack_low && n < 10) begin
			@(negedge ref_clk);
			n++;
		end
	endtask
endmodule

// >>> verification/readout_monitor.sv
`timescale 1ns/1ps
module readout_monitor (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [39:0] bus_in,
	input wire logic [39:0] bus_out,
	input wire logic bus_oe_upper,
	input wire logic bus_oe_lower,
	input wire logic command_strobe_low,
	input wire logic ack_low,
	input wire logic transfer_active,
	input wire logic data_strobe_low,
	input wire logic rdo_start,
	input wire logic rdo_ready,
	input wire logic rdo_valid,
	input wire logic [39:0] rdo_word,
	input wire logic [16*20-1:0] zs_all,
	input wire logic [9:0] zs_sample,
	input wire logic [3:0] zs_chan,
	input wire logic zs_keep
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic [9:0] smp_q;
	logic [9:0] thr_q;
	// Operands of the keep decision, one cycle behind like the output
	always_ff @(posedge ref_clk) begin
		smp_q <= zs_sample;
		thr_q <= zs_all[zs_chan*20 +: 10];
	end
	AST_ACK_CAUSE: assert property (
		$fell(ack_low) |-> !command_strobe_low && !$past(command_strobe_low))
		else $error("acknowledge fell without a held strobe");
	AST_ACK_HOLD: assert property (
		!ack_low && !command_strobe_low |=> !ack_low)
		else $error("acknowledge left while strobe held");
	AST_ACK_RELEASE: assert property (
		$rose(command_strobe_low) |-> ##[1:4] ack_low)
		else $error("acknowledge stuck after strobe release");
	AST_BROADCAST_FLAG_SILENT: assert property (
		!command_strobe_low && bus_in[38] |-> ack_low)
		else $error("broadcast word was acknowledged");
	AST_DSTB_XFER: assert property (
		!data_strobe_low |-> transfer_active)
		else $error("data strobe outside a transfer");
	AST_DSTB_WORD: assert property (
		!data_strobe_low |-> $past(rdo_valid) && $past(rdo_ready)
			&& bus_out == $past(rdo_word))
		else $error("readout word not the accepted one");
	AST_XFER_START: assert property (
		rdo_start |=> transfer_active)
		else $error("transfer line late after start");
	AST_ZS_KEEP: assert property (
		!$past(sys_rst) |-> zs_keep == (smp_q >= thr_q))
		else $error("suppression decision wrong");
	AST_OE_UPPER: assert property (
		bus_oe_upper |-> transfer_active)
		else $error("upper bus driven outside a transfer");
	AST_OE_LOWER: assert property (
		bus_oe_lower && !transfer_active |-> !ack_low)
		else $error("lower bus driven outside an answer");
	cover property ($fell(ack_low));
	cover property ($fell(data_strobe_low));
	cover property ($fell(transfer_active));
endmodule

bind readout_cmd_unit readout_monitor readout_monitor_inst (.ref_clk,
	.sys_rst, .bus_in, .bus_out, .bus_oe_upper, .bus_oe_lower,
	.command_strobe_low, .ack_low,
	.transfer_active, .data_strobe_low, .rdo_start, .rdo_ready, .rdo_valid,
	.rdo_word, .zs_all, .zs_sample, .zs_chan, .zs_keep);

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic sampling_clk = 1'b0;
	logic first_level_trigger = 1'b0;
	logic [15:0] channel_has_data = 16'h0021;
	logic [7:0] event_length = 8'h5e;
	logic [9:0] vpd_in = 10'h1c3;
	logic [9:0] zs_sample = 10'h000;
	logic [3:0] zs_chan = 4'h2;
	logic rdo_valid = 1'b0;
	logic rdo_done = 1'b0;
	logic acq_busy = 1'b0;
	logic [39:0] rdo_word = 40'h0;
	logic [39:0] bus_in;
	logic [39:0] bus_out;
	logic command_strobe_low, write_low, ack_low, transfer_active;
	logic data_strobe_low, rdo_start, rdo_ready, zs_keep, take, ack;
	logic [3:0] rdo_channel;
	logic [16*8*13-1:0] coef_all;
	logic [16*20-1:0] zs_all;
	logic [16*6-1:0] upper_bound_all;
	logic [16*7-1:0] lower_bound_all;
	logic [13:0] bc1_cfg;
	logic [9:0] ped_mem_addr;
	logic [15:0] chan_log = 16'h0;
	logic [19:0] rd;
	int fail_count = 0;
	int n_tests = 0;
	int words = 0;
	int left = 0;

	always #2 ref_clk = ~ref_clk;
	// Sampling clock free-running, phase unrelated to the bus clock
	initial begin
		#7;
		forever #32 sampling_clk = ~sampling_clk;
	end

	readout_cmd_unit readout_cmd_unit_inst (.ref_clk, .sys_rst,
		.chip_addr_strap(8'h3c), .bus_in, .bus_out, .bus_oe_upper(),
		.bus_oe_lower(), .command_strobe_low, .write_low, .ack_low,
		.transfer_active, .data_strobe_low, .first_level_trigger,
		.sampling_clk, .acq_busy, .channel_has_data, .event_length,
		.vpd_in, .ped_mem_rdata(10'h000), .sel_channel(), .ped_mem_we(),
		.ped_mem_addr, .ped_mem_wdata(), .l1_accept(), .rdo_start,
		.rdo_channel, .rdo_ready, .rdo_valid, .rdo_word, .rdo_done,
		.coef_all, .zs_all, .fped_all(), .upper_bound_all, .lower_bound_all,
		.bc1_cfg, .maf_cfg(), .trigger_timing_out(), .dpcfg_out(), .bfnpt_out(),
		.maf_sample(11'sh000), .maf_chan(4'h0), .maf_update_en(), .zs_sample,
		.zs_chan, .zs_keep);

	readout_ctrl_model ctrl_inst (.ref_clk, .ack_low, .bus_out, .bus_in,
		.command_strobe_low, .write_low);

	// Settled view: handshake taken, words counted, start order logged
	always @(negedge ref_clk) begin
		take = rdo_valid && rdo_ready;
		if (!data_strobe_low) words++;
		if (rdo_start) chan_log = {chan_log[11:0], rdo_channel};
	end
	// Datapath stand-in: two words per channel, then an end pulse
	always @(posedge ref_clk) begin
		#1;
		rdo_done = 1'b0;
		if (rdo_start) left = 2;
		else if (take) left = left - 1;
		if (take && left == 0) rdo_done = 1'b1;
		rdo_valid = left != 0;
		rdo_word = {34'h0, left[1:0], rdo_channel};
	end

	function automatic logic [39:0] mk(input logic b, input logic [3:0] ch,
		input logic [4:0] code, input logic [19:0] arg);
		logic [39:0] w;
		w = {1'b0, b, 1'b0, 8'h3c, ch, code, arg};
		w[39] = ^w[38:0]; // Even parity
		return w;
	endfunction
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Kind 0 read, 1 write with argument, 2 command
	task automatic op(input int k, input logic b, input logic [3:0] ch,
		input logic [4:0] code, input logic [19:0] arg);
		ctrl_inst.issue(mk(b, ch, code, arg), k != 0, k == 1, rd, ack);
		chk({19'h0, ack}, {19'h0, !b});
	endtask
	// Let a readout run out; bounded so a stuck transfer is reported
	task automatic drain();
		int n;
		n = 0;
		while (n < 300 && (n < 20 || transfer_active)) begin
			@(negedge ref_clk);
			n++;
		end
		chk({19'h0, transfer_active}, 20'h0);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		tally_and_finish();
	end

	initial begin
		repeat (8) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		op(0, 0, 0, 5'h10, 0);
		chk(rd, 20'h00900);
		op(1, 0, 0, 5'h17, 20'h1);
		op(0, 0, 0, 5'h10, 0);
		chk(rd & 20'hff000, 20'h02000);
		op(2, 1, 0, 5'h1d, 0);
		op(0, 0, 0, 5'h10, 0);
		chk(rd & 20'hff000, 20'h0);
		op(1, 0, 0, 5'h0b, 0);
		op(1, 0, 0, 5'h0d, 20'h003ff);
		chk({10'h0, ped_mem_addr}, 20'h003ff);
		op(0, 1, 0, 5'h0d, 0);
		op(0, 0, 0, 5'h0d, 0);
		chk(rd, 20'h003ff);
		op(0, 0, 0, 5'h10, 0);
		chk(rd & 20'hff000, 20'h02000);
		op(2, 1, 0, 5'h1d, 0);
		op(1, 0, 0, 5'h0e, 20'hc3ca7);
		op(1, 1, 0, 5'h0e, 20'h0);
		chk({6'h0, bc1_cfg}, 20'h03ca7);
		op(0, 0, 0, 5'h0e, 0);
		chk(rd, 20'h03ca7);
		op(1, 0, 3, 5'h14, 20'h0001f);
		chk({14'h0, upper_bound_all[18 +: 6]}, 20'h00024);
		chk({13'h0, lower_bound_all[21 +: 7]}, 20'h0005a);
		op(1, 1, 0, 5'h05, 20'h01abc);
		for (int c = 0; c < 16; c++) begin
			chk({7'h0, coef_all[c*104+65 +: 13]}, 20'h01abc);
		end
		op(1, 0, 2, 5'h08, 20'h55480);
		chk(zs_all[40 +: 20], 20'h55480);
		@(posedge ref_clk);
		#1 zs_sample = 10'h07f;
		repeat (2) @(posedge ref_clk);
		#1 chk({19'h0, zs_keep}, 20'h0);
		zs_sample = 10'h080;
		repeat (2) @(posedge ref_clk);
		#1 chk({19'h0, zs_keep}, 20'h1);
		op(1, 0, 1, 5'h0f, 20'h3f2aa);
		op(0, 0, 1, 5'h0f, 0);
		chk(rd, 20'h70eaa);
		op(0, 0, 0, 5'h13, 0);
		chk(rd, 20'h03c5e);
		op(0, 0, 0, 5'h17, 0);
		chk(rd, 20'h00021);
		@(posedge ref_clk);
		#1 first_level_trigger = 1'b1;
		repeat (4) @(posedge ref_clk);
		#1 first_level_trigger = 1'b0;
		op(2, 0, 0, 5'h18, 0);
		op(0, 0, 0, 5'h10, 0);
		chk(rd & 20'h00fff, 20'h000d0);
		words = 0;
		@(posedge ref_clk);
		#1 acq_busy = 1'b1;
		op(2, 0, 5, 5'h1a, 0);
		repeat (8) @(posedge ref_clk);
		#1 chk(words[19:0], 20'h0);
		acq_busy = 1'b0;
		drain();
		chk(words[19:0], 20'h2);
		chk({16'h0, chan_log[3:0]}, 20'h5);
		words = 0;
		op(2, 0, 0, 5'h1e, 0);
		drain();
		chk(words[19:0], 20'h4);
		chk({12'h0, chan_log[7:0]}, 20'h05);
		op(2, 0, 3, 5'h1a, 0);
		op(0, 0, 0, 5'h10, 0);
		chk(rd & 20'h80000, 20'h80000);
		op(2, 1, 0, 5'h19, 0);
		op(0, 0, 0, 5'h10, 0);
		chk(rd & 20'h00fff, 20'h00912);
		op(2, 1, 0, 5'h1b, 0);
		op(0, 0, 0, 5'h12, 0);
		chk(rd, 20'h00002);
		op(2, 1, 0, 5'h1c, 0);
		op(0, 0, 0, 5'h12, 0);
		chk(rd, 20'h00000);
		ctrl_inst.issue(mk(0, 0, 5'h12, 0) ^ {1'b1, 39'h0}, 0, 0, rd,
			ack);
		chk({19'h0, ack}, 20'h1);
		op(0, 0, 0, 5'h10, 0);
		chk(rd & 20'h01000, 20'h01000);
		tally_and_finish();
	end
endmodule
